// ---- logic/ipc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module ipc_top
  import ipc_pkg::*;
#(
  parameter int unsigned N_IN       = ipc_pkg::NUM_INPUTS,
  parameter int unsigned CYC_MS     = ipc_pkg::CYC_PER_MS,
  parameter int unsigned CYC_TENTH  = ipc_pkg::CYC_PER_TENTH_S
) (
  input  wire logic            CLK,
  input  wire logic            RST_B,
  input  wire logic [N_IN-1:0] DIGITAL_IN,
  input  wire logic            DRIVE_RUNNING,
  input  wire logic            COUNT_CLEAR,
  input  wire logic            TIMER_START,
  input  wire logic [3:0]      COUNT_MODE_WORD,
  input  wire logic [15:0]     COUNT_TARGET_SETTING,
  input  wire logic [15:0]     COUNT_MIDDLE_SETTING,
  input  wire logic [9:0]      ONE_SHOT_WIDTH_SETTING,
  input  wire logic [13:0]     TIMER_ONE_PERIOD,
  input  wire logic            INPUT_POLARITY_SELECT,
  input  wire logic [15:0]     INPUT_DEBOUNCE_TIME,
  output logic [N_IN-1:0]      INPUT_LEVEL,
  output logic [15:0]          COUNT_VALUE,
  output logic                 COUNT_LENGTH_UNITS,
  output logic                 COUNT_TARGET_REACHED,
  output logic                 COUNT_MIDDLE_REACHED,
  output logic                 DRIVE_STOP_REQ,
  output logic                 ONE_SHOT_OUT,
  output logic                 TIMER_EXPIRED
);
  import ipc_pkg::*;

  logic [1:0]      rst_sync_reg;
  logic            rst_n;
  logic [N_IN-1:0] lvl;
  logic [N_IN-1:0] lvl_reg;
  logic            pulse_prev_reg;
  logic            pulse_edge;
  logic            pol_reg;
  logic [13:0]     tper_reg;
  logic [13:0]     tper_next;
  logic [15:0]     tgt;
  logic [9:0]      shot_w;

  // Counter state
  logic [15:0]     cnt_reg;
  logic [15:0]     cnt_next;
  logic            hit_reg;
  logic            hit_next;
  logic            mid_reg;
  logic            mid_next;
  logic            stop_reg;
  logic            stop_next;
  logic            reach;

  // One-shot and timer state
  logic [31:0]     shot_cyc_reg;
  logic [31:0]     shot_cyc_next;
  logic [9:0]      shot_ten_reg;
  logic [9:0]      shot_ten_next;
  logic            shot_reg;
  logic            shot_next;
  logic [31:0]     tm_cyc_reg;
  logic [31:0]     tm_cyc_next;
  logic [13:0]     tm_ten_reg;
  logic [13:0]     tm_ten_next;
  logic            tm_exp_reg;
  logic            tm_exp_next;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in
      ipc_debounce #(
        .CYC_MS (CYC_MS)
      ) u_deb (
        .clk    (CLK),
        .rst_n  (rst_n),
        .raw_in (DIGITAL_IN[gi]),
        .invert (pol_reg),
        .deb_ms (INPUT_DEBOUNCE_TIME),
        .level  (lvl[gi])
      );
    end
  endgenerate

  always_comb begin
    // Clamp settings into their legal ranges
    tgt    = (COUNT_TARGET_SETTING > TARGET_MAX) ? TARGET_MAX : COUNT_TARGET_SETTING;
    shot_w = (ONE_SHOT_WIDTH_SETTING < SHOT_MIN) ? SHOT_MIN :
             (ONE_SHOT_WIDTH_SETTING > SHOT_MAX) ? SHOT_MAX : ONE_SHOT_WIDTH_SETTING;
    // Period only taken while the drive stands
    tper_next = tper_reg;
    if (!DRIVE_RUNNING) begin
      tper_next = (TIMER_ONE_PERIOD < TIMER_MIN) ? TIMER_MIN :
                  (TIMER_ONE_PERIOD > TIMER_MAX) ? TIMER_MAX : TIMER_ONE_PERIOD;
    end
    pulse_edge = lvl[PULSE_IN_IDX] & ~pulse_prev_reg;
  end

  always_comb begin
    cnt_next  = cnt_reg;
    hit_next  = hit_reg;
    mid_next  = mid_reg;
    stop_next = stop_reg;
    reach     = 1'b0;
    if (COUNT_CLEAR) begin
      cnt_next  = '0;
      hit_next  = 1'b0;
      mid_next  = 1'b0;
      stop_next = 1'b0;
    end
    if (pulse_edge) begin
      // Saturate instead of wrapping so an uncleared count never falls back
      if (cnt_next != 16'hFFFF) begin
        cnt_next = cnt_next + 16'h0001;
      end
      if (cnt_next == COUNT_MIDDLE_SETTING) begin
        mid_next = 1'b1;
      end
      if (cnt_next == tgt) begin
        reach    = 1'b1;
        hit_next = 1'b1;
        if (!COUNT_MODE_WORD[MODE_STOP_POS]) begin
          stop_next = 1'b1;
        end
        if (COUNT_MODE_WORD[MODE_CLR_POS]) begin
          cnt_next = '0;
        end
      end
    end
  end

  always_comb begin
    shot_cyc_next = shot_cyc_reg;
    shot_ten_next = shot_ten_reg;
    shot_next     = shot_reg;
    if (reach && COUNT_MODE_WORD[MODE_SHOT_POS]) begin
      shot_next     = 1'b1;
      shot_cyc_next = '0;
      shot_ten_next = '0;
    end else if (shot_reg) begin
      if (shot_cyc_reg == CYC_TENTH - 1) begin
        shot_cyc_next = '0;
        if (shot_ten_reg + 10'h001 >= shot_w) begin
          shot_next = 1'b0;
        end else begin
          shot_ten_next = shot_ten_reg + 10'h001;
        end
      end else begin
        shot_cyc_next = shot_cyc_reg + 32'h0000_0001;
      end
    end
  end

  always_comb begin
    tm_cyc_next = tm_cyc_reg;
    tm_ten_next = tm_ten_reg;
    tm_exp_next = tm_exp_reg;
    if (TIMER_START) begin
      tm_cyc_next = '0;
      tm_ten_next = '0;
      tm_exp_next = 1'b0;
    end else if (!tm_exp_reg) begin
      if (tm_cyc_reg == CYC_TENTH - 1) begin
        tm_cyc_next = '0;
        if (tm_ten_reg + 14'h0001 >= tper_reg) begin
          tm_exp_next = 1'b1;
        end else begin
          tm_ten_next = tm_ten_reg + 14'h0001;
        end
      end else begin
        tm_cyc_next = tm_cyc_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      lvl_reg        <= '0;
      pulse_prev_reg <= 1'b0;
      pol_reg        <= POL_DEF;
      tper_reg       <= TIMER_DEF;
      cnt_reg        <= 16'h0000;
      hit_reg        <= 1'b0;
      mid_reg        <= 1'b0;
      stop_reg       <= 1'b0;
      shot_cyc_reg   <= 32'h0000_0000;
      shot_ten_reg   <= 10'h000;
      shot_reg       <= 1'b0;
      tm_cyc_reg     <= 32'h0000_0000;
      tm_ten_reg     <= 14'h0000;
      tm_exp_reg     <= 1'b0;
    end else begin
      lvl_reg        <= lvl;
      pulse_prev_reg <= lvl[PULSE_IN_IDX];
      // Polarity is wiring-related, so it only changes while stopped
      pol_reg        <= DRIVE_RUNNING ? pol_reg : INPUT_POLARITY_SELECT;
      tper_reg       <= tper_next;
      cnt_reg        <= cnt_next;
      hit_reg        <= hit_next;
      mid_reg        <= mid_next;
      stop_reg       <= stop_next;
      shot_cyc_reg   <= shot_cyc_next;
      shot_ten_reg   <= shot_ten_next;
      shot_reg       <= shot_next;
      tm_cyc_reg     <= tm_cyc_next;
      tm_ten_reg     <= tm_ten_next;
      tm_exp_reg     <= tm_exp_next;
    end
  end

  logic units_reg;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      units_reg <= 1'b1;
    end else begin
      units_reg <= ~COUNT_MODE_WORD[MODE_UNIT_POS];
    end
  end

  assign INPUT_LEVEL          = lvl_reg;
  assign COUNT_VALUE          = cnt_reg;
  assign COUNT_LENGTH_UNITS   = units_reg;
  assign COUNT_TARGET_REACHED = hit_reg;
  assign COUNT_MIDDLE_REACHED = mid_reg;
  assign DRIVE_STOP_REQ       = stop_reg;
  assign ONE_SHOT_OUT         = shot_reg;
  assign TIMER_EXPIRED        = tm_exp_reg;
endmodule
`default_nettype wire

// ---- logic/ipc_pkg.sv ----
`default_nettype none
package ipc_pkg;
  // Clock rate and tick derivation
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / MS_PER_S;
  localparam int unsigned TENTH_S_MS      = 100;
  localparam int unsigned CYC_PER_TENTH_S = CYC_PER_MS * TENTH_S_MS;
  // Input terminal count
  localparam int unsigned NUM_INPUTS      = 8;
  // Pulse input terminal index within the input group
  localparam int unsigned PULSE_IN_IDX    = 4;
  // Count mode word digit positions (one bit per decimal digit)
  localparam int unsigned MODE_UNIT_POS   = 0;
  localparam int unsigned MODE_STOP_POS   = 1;
  localparam int unsigned MODE_SHOT_POS   = 2;
  localparam int unsigned MODE_CLR_POS    = 3;
  // Setting ranges and defaults
  localparam logic [15:0] TARGET_MAX      = 16'hFFDC;
  localparam logic [15:0] TARGET_DEF      = 16'h0001;
  localparam logic [9:0]  SHOT_MIN        = 10'h001;
  localparam logic [9:0]  SHOT_MAX        = 10'h28A;
  localparam logic [9:0]  SHOT_DEF        = 10'h001;
  localparam logic [13:0] TIMER_MIN       = 14'h0001;
  localparam logic [13:0] TIMER_MAX       = 14'h270F;
  localparam logic [13:0] TIMER_DEF       = 14'h0001;
  localparam logic [15:0] DEB_MAX_MS      = 16'hEA60;
  localparam logic [15:0] DEB_DEF_MS      = 16'h0014;
  localparam logic [3:0]  MODE_DEF        = 4'h0;
  localparam logic        POL_DEF         = 1'b0;
endpackage
`default_nettype wire

// ---- logic/ipc_debounce.sv ----
`timescale 1ns/100ps
`default_nettype none
module ipc_debounce #(
  parameter int unsigned CYC_MS = 40000
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        raw_in,
  input  wire logic        invert,
  input  wire logic [15:0] deb_ms,
  output logic             level
);
  import ipc_pkg::*;
  logic [2:0]  sync_reg;
  logic [2:0]  sync_next;
  logic [15:0] cyc_reg;
  logic [15:0] cyc_next;
  logic [15:0] ms_reg;
  logic [15:0] ms_next;
  logic        lvl_reg;
  logic        lvl_next;
  logic        cand;
  logic        agree;
  logic [15:0] limit;

  assign level = lvl_reg;

  always_comb begin
    sync_next = {sync_reg[1:0], raw_in};
    // Only stages two and three are looked at
    agree     = (sync_reg[1] == sync_reg[2]);
    cand      = sync_reg[2] ^ invert;
    limit     = (deb_ms > DEB_MAX_MS) ? DEB_MAX_MS : deb_ms;
    cyc_next  = cyc_reg;
    ms_next   = ms_reg;
    lvl_next  = lvl_reg;
    if (!agree || cand == lvl_reg) begin
      cyc_next = '0;
      ms_next  = '0;
    end else if (ms_reg >= limit) begin
      lvl_next = cand;
      cyc_next = '0;
      ms_next  = '0;
    end else if (cyc_reg == 16'(CYC_MS - 1)) begin
      cyc_next = '0;
      ms_next  = ms_reg + 16'h0001;
    end else begin
      cyc_next = cyc_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= 3'h0;
      cyc_reg  <= 16'h0000;
      ms_reg   <= 16'h0000;
      lvl_reg  <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      cyc_reg  <= cyc_next;
      ms_reg   <= ms_next;
      lvl_reg  <= lvl_next;
    end
  end
endmodule
`default_nettype wire

// ---- test/ipc_top_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module ipc_top_chk
  import ipc_pkg::*;
#(
  parameter int unsigned N_IN      = NUM_INPUTS,
  parameter int unsigned CYC_TENTH = CYC_PER_TENTH_S
) (
  input wire logic            CLK,
  input wire logic            RST_B,
  input wire logic [N_IN-1:0] DIGITAL_IN,
  input wire logic            DRIVE_RUNNING,
  input wire logic            COUNT_CLEAR,
  input wire logic            TIMER_START,
  input wire logic [3:0]      COUNT_MODE_WORD,
  input wire logic [15:0]     COUNT_TARGET_SETTING,
  input wire logic [15:0]     COUNT_MIDDLE_SETTING,
  input wire logic [9:0]      ONE_SHOT_WIDTH_SETTING,
  input wire logic [13:0]     TIMER_ONE_PERIOD,
  input wire logic            INPUT_POLARITY_SELECT,
  input wire logic [15:0]     COUNT_VALUE,
  input wire logic            COUNT_LENGTH_UNITS,
  input wire logic            COUNT_TARGET_REACHED,
  input wire logic            COUNT_MIDDLE_REACHED,
  input wire logic            DRIVE_STOP_REQ,
  input wire logic            ONE_SHOT_OUT,
  input wire logic            TIMER_EXPIRED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic [31:0] len_reg;
  logic [31:0] len_next;
  logic [31:0] since_reg;
  logic [31:0] since_next;
  // Saturates so an expiry before any start is never judged
  always_comb begin
    len_next   = ONE_SHOT_OUT ? len_reg + 32'h0000_0001 : 32'h0000_0000;
    since_next = TIMER_START ? 32'h0000_0000 : since_reg + 32'(~&since_reg);
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      len_reg   <= 32'h0000_0000;
      since_reg <= 32'hFFFF_FFFF;
    end else begin
      len_reg   <= len_next;
      since_reg <= since_next;
    end
  end
  AST_UNITS: assert property ($stable(COUNT_MODE_WORD[0]) |=>
    COUNT_LENGTH_UNITS != $past(COUNT_MODE_WORD[0])) else $error("length flag wrong");
  AST_STOP: assert property ($rose(COUNT_TARGET_REACHED) |->
    DRIVE_STOP_REQ == !COUNT_MODE_WORD[1]) else $error("stop request wrong");
  AST_SHOT: assert property ($rose(COUNT_TARGET_REACHED) && COUNT_MODE_WORD[2] |->
    $rose(ONE_SHOT_OUT)) else $error("one-shot missing");
  AST_SHOT_SRC: assert property ($rose(ONE_SHOT_OUT) |->
    COUNT_TARGET_REACHED && COUNT_MODE_WORD[2]) else $error("one-shot unasked");
  AST_WIDTH: assert property ($fell(ONE_SHOT_OUT) |->
    len_reg == ONE_SHOT_WIDTH_SETTING * CYC_TENTH) else $error("one-shot width wrong");
  AST_AUTO_CLR: assert property ($rose(COUNT_TARGET_REACHED) |-> ##[0:1]
    COUNT_VALUE == (COUNT_MODE_WORD[3] ? 16'h0000 : COUNT_TARGET_SETTING)) else $error("count after target");
  AST_CLEAR: assert property ((COUNT_CLEAR && DIGITAL_IN[PULSE_IN_IDX] == INPUT_POLARITY_SELECT) [*8] |=>
    COUNT_VALUE == 16'h0000 && !COUNT_TARGET_REACHED && !COUNT_MIDDLE_REACHED && !DRIVE_STOP_REQ)
    else $error("clear incomplete");
  AST_MIDDLE: assert property ($rose(COUNT_MIDDLE_REACHED) |->
    COUNT_VALUE == COUNT_MIDDLE_SETTING || $past(COUNT_VALUE) == COUNT_MIDDLE_SETTING) else $error("middle flag");
  AST_TSTART: assert property (TIMER_START |=> !TIMER_EXPIRED) else $error("timer flag kept");
  AST_TPERIOD: assert property ($rose(TIMER_EXPIRED) && !DRIVE_RUNNING && ~&since_reg |->
    since_reg + 2 >= TIMER_ONE_PERIOD * CYC_TENTH && since_reg <= TIMER_ONE_PERIOD * CYC_TENTH + 2)
    else $error("timer period wrong");
endmodule
bind ipc_top ipc_top_chk #(.N_IN(N_IN), .CYC_TENTH(CYC_TENTH)) chk (.CLK, .RST_B, .DIGITAL_IN, .DRIVE_RUNNING,
  .COUNT_CLEAR, .TIMER_START, .COUNT_MODE_WORD, .COUNT_TARGET_SETTING, .COUNT_MIDDLE_SETTING,
  .ONE_SHOT_WIDTH_SETTING, .TIMER_ONE_PERIOD, .INPUT_POLARITY_SELECT, .COUNT_VALUE, .COUNT_LENGTH_UNITS,
  .COUNT_TARGET_REACHED, .COUNT_MIDDLE_REACHED, .DRIVE_STOP_REQ, .ONE_SHOT_OUT, .TIMER_EXPIRED);
`default_nettype wire

// ---- test/ipc_pin_src.sv ----
`timescale 1ns/100ps
`default_nettype none
module ipc_pin_src #(
  parameter int unsigned N = 8
) (
  input  wire logic    clk,
  input  wire logic    pol,
  output logic [N-1:0] pins
);
  logic [N-1:0] act_reg = '0;
  // Sourcing wiring idles high, so the pin is the contact state crossed with polarity
  assign pins = act_reg ^ {N{pol}};
  task automatic drive(input int idx, input logic v, input int n);
    @(posedge clk);
    act_reg[idx] <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int unsigned CT = 40;
  logic        CLK = 1'b0;
  logic        RST_B = 1'b0;
  logic [7:0]  DIGITAL_IN;
  logic        DRIVE_RUNNING = 1'b0;
  logic        COUNT_CLEAR = 1'b0;
  logic        TIMER_START = 1'b0;
  logic [3:0]  COUNT_MODE_WORD = 4'h0;
  logic [15:0] COUNT_TARGET_SETTING = 16'h0002;
  logic [15:0] COUNT_MIDDLE_SETTING = 16'h0001;
  logic [9:0]  ONE_SHOT_WIDTH_SETTING = 10'h002;
  logic [13:0] TIMER_ONE_PERIOD = 14'h0001;
  logic        INPUT_POLARITY_SELECT = 1'b0;
  logic [15:0] INPUT_DEBOUNCE_TIME = 16'h0002;
  logic [7:0]  INPUT_LEVEL;
  logic [15:0] COUNT_VALUE;
  logic        COUNT_LENGTH_UNITS, COUNT_TARGET_REACHED, COUNT_MIDDLE_REACHED;
  logic        DRIVE_STOP_REQ, ONE_SHOT_OUT, TIMER_EXPIRED;
  int          n_mismatch = 0;
  int          comparisons = 0;
  ipc_top #(.CYC_MS(4), .CYC_TENTH(CT)) uut (.CLK, .RST_B, .DIGITAL_IN, .DRIVE_RUNNING, .COUNT_CLEAR,
    .TIMER_START, .COUNT_MODE_WORD, .COUNT_TARGET_SETTING, .COUNT_MIDDLE_SETTING, .ONE_SHOT_WIDTH_SETTING,
    .TIMER_ONE_PERIOD, .INPUT_POLARITY_SELECT, .INPUT_DEBOUNCE_TIME, .INPUT_LEVEL, .COUNT_VALUE,
    .COUNT_LENGTH_UNITS, .COUNT_TARGET_REACHED, .COUNT_MIDDLE_REACHED, .DRIVE_STOP_REQ, .ONE_SHOT_OUT,
    .TIMER_EXPIRED);
  ipc_pin_src src (.clk(CLK), .pol(INPUT_POLARITY_SELECT), .pins(DIGITAL_IN));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Held long enough for a pending count edge to be swept away too
  task automatic clear();
    @(posedge CLK);
    COUNT_CLEAR <= 1'b1;
    repeat (8) @(posedge CLK);
    COUNT_CLEAR <= 1'b0;
  endtask
  task automatic pulse(input int n);
    src.drive(4, 1'b1, n);
    src.drive(4, 1'b0, 20);
  endtask
  initial begin
    forever #12.5 CLK = ~CLK;
  end
  initial begin
    repeat (10000) @(posedge CLK);
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge CLK);
    chk(COUNT_VALUE, 16'h0000);
    chk(COUNT_TARGET_REACHED, 1'b0);
    chk(COUNT_MIDDLE_REACHED, 1'b0);
    chk(DRIVE_STOP_REQ, 1'b0);
    chk(ONE_SHOT_OUT, 1'b0);
    chk(COUNT_LENGTH_UNITS, 1'b1);
    chk(INPUT_LEVEL, 8'h00);
    $display("test reset done");
    for (int m = 0; m < 16; m++) begin
      @(posedge CLK);
      COUNT_MODE_WORD <= 4'(m);
      clear();
      pulse(20);
      chk(COUNT_VALUE, 16'h0001);
      chk(COUNT_MIDDLE_REACHED, 1'b1);
      pulse(20);
      chk(COUNT_TARGET_REACHED, 1'b1);
      chk(COUNT_VALUE, m[3] ? 16'h0000 : 16'h0002);
      chk(DRIVE_STOP_REQ, !m[1]);
      chk(ONE_SHOT_OUT, m[2]);
      chk(COUNT_LENGTH_UNITS, !m[0]);
      // Still high just before its width runs out, low soon after
      repeat (2 * CT - 30) @(posedge CLK);
      chk(ONE_SHOT_OUT, m[2]);
      repeat (50) @(posedge CLK);
      chk(ONE_SHOT_OUT, 1'b0);
    end
    $display("test modes done");
    clear();
    for (int i = 0; i < 8; i++) begin
      if (i != 4) begin
        src.drive(i, 1'b1, 20);
        chk(INPUT_LEVEL[i], 1'b1);
        src.drive(i, 1'b0, 20);
        chk(COUNT_VALUE, 16'h0000);
      end
    end
    $display("test other inputs done");
    for (int d = 2; d >= 0; d -= 2) begin
      @(posedge CLK);
      INPUT_DEBOUNCE_TIME <= 16'(d);
      clear();
      pulse(6);
      chk(COUNT_VALUE, d == 0 ? 16'h0001 : 16'h0000);
    end
    $display("test debounce done");
    @(posedge CLK);
    INPUT_DEBOUNCE_TIME <= 16'h0002;
    INPUT_POLARITY_SELECT <= 1'b1;
    repeat (20) @(posedge CLK);
    chk(INPUT_LEVEL, 8'h00);
    src.drive(0, 1'b1, 20);
    chk(INPUT_LEVEL, 8'h01);
    src.drive(0, 1'b0, 20);
    $display("test polarity done");
    @(posedge CLK);
    TIMER_START <= 1'b1;
    @(posedge CLK);
    TIMER_START <= 1'b0;
    repeat (CT - 8) @(posedge CLK);
    chk(TIMER_EXPIRED, 1'b0);
    repeat (16) @(posedge CLK);
    chk(TIMER_EXPIRED, 1'b1);
    @(posedge CLK);
    DRIVE_RUNNING <= 1'b1;
    TIMER_ONE_PERIOD <= 14'h0003;
    TIMER_START <= 1'b1;
    @(posedge CLK);
    TIMER_START <= 1'b0;
    repeat (CT + 8) @(posedge CLK);
    chk(TIMER_EXPIRED, 1'b1);
    $display("test timer done");
    complete_run();
  end
endmodule
`default_nettype wire
